/* src/cfcd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - 57H 57H: 16-bit group write, 160 points
// - 51H 57H: word batch write, 64 points
// - 42H/4AH 54H: single bit set/reset, 20 points
// - 57H 54H: random 16-bit group test, 160 points
// - 51H 54H: random word write, 10 points
// - 4AH 4DH: register single bits, 40 points
// - 57H 4DH: register 16-bit groups, 320 points
// - 51H 4DH: register word devices, 20 points
// - 4DH 42H/4AH/4EH/51H: read registered devices
// - 54H 52H: read unit buffer memory
// - 54H 57H: write unit buffer, 128 bytes
// - 45H 52H: extension file read, 64 points
// - 45H 57H batch 64, 45H 54H random 10
// - 45H 4DH: register extension file, 20 points
// - 4DH 45H: read registered extension file points
// - 4EH 52H: flat serial read, 64 points
// - 4EH 57H: flat serial write, block derived
// - Write commands refused in run when forbidden
module cfcd_decoder (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Command from the frame parser
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_CODE_HI,
  input wire logic [7:0] CMD_CODE_LO,
  input wire logic [cfcd_pkg::PTS_W-1:0] CMD_POINTS,
  input wire logic [cfcd_pkg::ADDR_W-1:0] CMD_ADDR,
  // CPU state pins
  input wire logic CPU_RUN,
  input wire logic RUN_WRITE_PERMIT,
  // Access stream to memories
  output logic ACC_VALID,
  input wire logic ACC_READY,
  output cfcd_pkg::cfcd_op_e ACC_OP,
  output logic ACC_WRITE,
  output logic [cfcd_pkg::PTS_W-1:0] ACC_INDEX,
  output logic [cfcd_pkg::ADDR_W-1:0] ACC_ADDR,
  output logic [cfcd_pkg::BLK_W-1:0] ACC_BLOCK,
  // Answer to the host side
  output logic RESP_VALID,
  output logic RESP_NAK,
  output logic [cfcd_pkg::ERR_W-1:0] RESP_ERR
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHECK,
    ST_ACCESS,
    ST_RESP
  } cfcd_state_e;

  // Map a code pair to an operation
  function automatic cfcd_pkg::cfcd_op_e decode_op(input logic [7:0] hi, input logic [7:0] lo);
    cfcd_pkg::cfcd_op_e op;
    case ({hi, lo})
      {cfcd_pkg::CH_W, cfcd_pkg::CH_W}: op = cfcd_pkg::OP_BIT16_BATCH_WRITE;
      {cfcd_pkg::CH_Q, cfcd_pkg::CH_W}: op = cfcd_pkg::OP_WORD_DEV_BATCH_WRITE;
      {cfcd_pkg::CH_B, cfcd_pkg::CH_T}: op = cfcd_pkg::OP_SINGLE_BIT_TEST_SET;
      {cfcd_pkg::CH_J, cfcd_pkg::CH_T}: op = cfcd_pkg::OP_SINGLE_BIT_TEST_SET;
      {cfcd_pkg::CH_W, cfcd_pkg::CH_T}: op = cfcd_pkg::OP_BIT16_TEST_SET;
      {cfcd_pkg::CH_Q, cfcd_pkg::CH_T}: op = cfcd_pkg::OP_WORD_RANDOM_WRITE;
      {cfcd_pkg::CH_J, cfcd_pkg::CH_M}: op = cfcd_pkg::OP_SINGLE_BIT_WATCH_REGISTER;
      {cfcd_pkg::CH_W, cfcd_pkg::CH_M}: op = cfcd_pkg::OP_BIT16_WATCH_REGISTER;
      {cfcd_pkg::CH_Q, cfcd_pkg::CH_M}: op = cfcd_pkg::OP_WORD_WATCH_REGISTER;
      {cfcd_pkg::CH_M, cfcd_pkg::CH_B}: op = cfcd_pkg::OP_DEV_WATCH_RUN;
      {cfcd_pkg::CH_M, cfcd_pkg::CH_J}: op = cfcd_pkg::OP_DEV_WATCH_RUN;
      {cfcd_pkg::CH_M, cfcd_pkg::CH_N}: op = cfcd_pkg::OP_DEV_WATCH_RUN;
      {cfcd_pkg::CH_M, cfcd_pkg::CH_Q}: op = cfcd_pkg::OP_DEV_WATCH_RUN;
      {cfcd_pkg::CH_T, cfcd_pkg::CH_R}: op = cfcd_pkg::OP_UNIT_BUFFER_READ;
      {cfcd_pkg::CH_T, cfcd_pkg::CH_W}: op = cfcd_pkg::OP_UNIT_BUFFER_WRITE;
      {cfcd_pkg::CH_E, cfcd_pkg::CH_R}: op = cfcd_pkg::OP_XFILE_BATCH_READ;
      {cfcd_pkg::CH_E, cfcd_pkg::CH_W}: op = cfcd_pkg::OP_XFILE_BATCH_WRITE;
      {cfcd_pkg::CH_E, cfcd_pkg::CH_T}: op = cfcd_pkg::OP_XFILE_RANDOM_WRITE;
      {cfcd_pkg::CH_E, cfcd_pkg::CH_M}: op = cfcd_pkg::OP_XFILE_WATCH_REGISTER;
      {cfcd_pkg::CH_M, cfcd_pkg::CH_E}: op = cfcd_pkg::OP_XFILE_WATCH_RUN;
      {cfcd_pkg::CH_N, cfcd_pkg::CH_R}: op = cfcd_pkg::OP_XFILE_FLAT_READ;
      {cfcd_pkg::CH_N, cfcd_pkg::CH_W}: op = cfcd_pkg::OP_XFILE_FLAT_WRITE;
      default: op = cfcd_pkg::OP_NONE;
    endcase
    return op;
  endfunction

  // Largest point count for each operation; monitor runs take none
  function automatic logic [cfcd_pkg::PTS_W-1:0] op_limit(input cfcd_pkg::cfcd_op_e op);
    logic [cfcd_pkg::PTS_W-1:0] lim;
    case (op)
      cfcd_pkg::OP_BIT16_BATCH_WRITE: lim = cfcd_pkg::LIM_BIT16_WR;
      cfcd_pkg::OP_WORD_DEV_BATCH_WRITE: lim = cfcd_pkg::LIM_WORD_WR;
      cfcd_pkg::OP_SINGLE_BIT_TEST_SET: lim = cfcd_pkg::LIM_BIT_TEST;
      cfcd_pkg::OP_BIT16_TEST_SET: lim = cfcd_pkg::LIM_BIT16_TEST;
      cfcd_pkg::OP_WORD_RANDOM_WRITE: lim = cfcd_pkg::LIM_WORD_RAND;
      cfcd_pkg::OP_SINGLE_BIT_WATCH_REGISTER: lim = cfcd_pkg::LIM_BIT_WATCH;
      cfcd_pkg::OP_BIT16_WATCH_REGISTER: lim = cfcd_pkg::LIM_BIT16_WATCH;
      cfcd_pkg::OP_WORD_WATCH_REGISTER: lim = cfcd_pkg::LIM_WORD_WATCH;
      cfcd_pkg::OP_UNIT_BUFFER_READ: lim = cfcd_pkg::LIM_UBUF_RD;
      cfcd_pkg::OP_UNIT_BUFFER_WRITE: lim = cfcd_pkg::LIM_UBUF_WR;
      cfcd_pkg::OP_XFILE_BATCH_READ: lim = cfcd_pkg::LIM_XF_BATCH;
      cfcd_pkg::OP_XFILE_BATCH_WRITE: lim = cfcd_pkg::LIM_XF_BATCH;
      cfcd_pkg::OP_XFILE_RANDOM_WRITE: lim = cfcd_pkg::LIM_XF_RAND;
      cfcd_pkg::OP_XFILE_WATCH_REGISTER: lim = cfcd_pkg::LIM_XF_WATCH;
      cfcd_pkg::OP_XFILE_FLAT_READ: lim = cfcd_pkg::LIM_XF_FLAT;
      cfcd_pkg::OP_XFILE_FLAT_WRITE: lim = cfcd_pkg::LIM_XF_FLAT;
      default: lim = cfcd_pkg::RST_COUNT;
    endcase
    return lim;
  endfunction

  cfcd_state_e state;
  cfcd_state_e next_state;
  logic [7:0] code_hi;
  logic [7:0] next_code_hi;
  logic [7:0] code_lo;
  logic [7:0] next_code_lo;
  logic [cfcd_pkg::PTS_W-1:0] points;
  logic [cfcd_pkg::PTS_W-1:0] next_points;
  logic [cfcd_pkg::ADDR_W-1:0] start_addr;
  logic [cfcd_pkg::ADDR_W-1:0] next_start_addr;
  logic [cfcd_pkg::PTS_W-1:0] count;
  logic [cfcd_pkg::PTS_W-1:0] next_count;
  cfcd_pkg::cfcd_op_e next_acc_op;
  logic next_acc_write;
  logic [cfcd_pkg::PTS_W-1:0] next_acc_index;
  logic [cfcd_pkg::ADDR_W-1:0] next_acc_addr;
  logic [cfcd_pkg::BLK_W-1:0] next_acc_block;
  logic next_resp_nak;
  logic [cfcd_pkg::ERR_W-1:0] next_resp_err;
  logic run_sync;
  logic permit_sync;
  logic write_locked;
  cfcd_pkg::cfcd_op_e dec_op;
  logic dec_write;
  logic dec_group;
  logic dec_flat;
  logic [cfcd_pkg::PTS_W-1:0] dec_limit;
  logic [cfcd_pkg::ADDR_W-1:0] addr_step;
  logic reg_we;
  logic reg_xfile;
  logic [cfcd_pkg::PTS_W-1:0] dev_count;
  logic [cfcd_pkg::PTS_W-1:0] xf_count;

  // CPU state pins come from another domain
  cfcd_sync u_run_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .async_in(CPU_RUN),
    .sync_out(run_sync)
  );

  cfcd_sync u_permit_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .async_in(RUN_WRITE_PERMIT),
    .sync_out(permit_sync)
  );

  // Last registered sets; a run before registration just answers empty
  cfcd_watch u_watch (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .reg_we(reg_we),
    .reg_xfile(reg_xfile),
    .reg_count(count),
    .dev_count(dev_count),
    .xf_count(xf_count)
  );

  // Classify the latched code pair
  always_comb begin
    dec_op = decode_op(code_hi, code_lo);
    dec_limit = op_limit(dec_op);
    dec_write = (dec_op == cfcd_pkg::OP_BIT16_BATCH_WRITE) ||
                (dec_op == cfcd_pkg::OP_WORD_DEV_BATCH_WRITE) ||
                (dec_op == cfcd_pkg::OP_SINGLE_BIT_TEST_SET) ||
                (dec_op == cfcd_pkg::OP_BIT16_TEST_SET) ||
                (dec_op == cfcd_pkg::OP_WORD_RANDOM_WRITE) ||
                (dec_op == cfcd_pkg::OP_UNIT_BUFFER_WRITE) ||
                (dec_op == cfcd_pkg::OP_XFILE_BATCH_WRITE) ||
                (dec_op == cfcd_pkg::OP_XFILE_RANDOM_WRITE) ||
                (dec_op == cfcd_pkg::OP_XFILE_FLAT_WRITE);
    dec_group = (dec_op == cfcd_pkg::OP_BIT16_BATCH_WRITE) ||
                (dec_op == cfcd_pkg::OP_BIT16_TEST_SET) ||
                (dec_op == cfcd_pkg::OP_BIT16_WATCH_REGISTER);
    dec_flat = (dec_op == cfcd_pkg::OP_XFILE_FLAT_READ) ||
               (dec_op == cfcd_pkg::OP_XFILE_FLAT_WRITE);
    write_locked = run_sync && !permit_sync;
  end

  // Handshakes are decoded straight from the state
  always_comb begin
    CMD_READY = (state == ST_IDLE);
    ACC_VALID = (state == ST_ACCESS);
    RESP_VALID = (state == ST_RESP);
    reg_we = (state == ST_RESP) && !RESP_NAK &&
             ((ACC_OP == cfcd_pkg::OP_SINGLE_BIT_WATCH_REGISTER) ||
              (ACC_OP == cfcd_pkg::OP_BIT16_WATCH_REGISTER) ||
              (ACC_OP == cfcd_pkg::OP_WORD_WATCH_REGISTER) ||
              (ACC_OP == cfcd_pkg::OP_XFILE_WATCH_REGISTER));
    reg_xfile = (ACC_OP == cfcd_pkg::OP_XFILE_WATCH_REGISTER);
    addr_step = ACC_ADDR + cfcd_pkg::ADDR_W'(1);
  end

  // Command sequencer: take, check, walk the accesses, answer
  always_comb begin
    next_state = state;
    next_code_hi = code_hi;
    next_code_lo = code_lo;
    next_points = points;
    next_start_addr = start_addr;
    next_count = count;
    next_acc_op = ACC_OP;
    next_acc_write = ACC_WRITE;
    next_acc_index = ACC_INDEX;
    next_acc_addr = ACC_ADDR;
    next_acc_block = ACC_BLOCK;
    next_resp_nak = RESP_NAK;
    next_resp_err = RESP_ERR;
    case (state)
      ST_IDLE: begin
        if (CMD_VALID) begin
          next_code_hi = CMD_CODE_HI;
          next_code_lo = CMD_CODE_LO;
          next_points = CMD_POINTS;
          next_start_addr = CMD_ADDR;
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_acc_op = dec_op;
        next_acc_write = dec_write;
        next_acc_index = cfcd_pkg::RST_COUNT;
        next_acc_addr = start_addr;
        next_acc_block = dec_flat ? start_addr[cfcd_pkg::ADDR_W-1:cfcd_pkg::XF_BLOCK_LSB] :
                         cfcd_pkg::BLK_W'(0);
        next_resp_nak = 1'b1;
        next_resp_err = cfcd_pkg::ERR_NONE;
        next_count = dec_group ? (points >> cfcd_pkg::GROUP_SHIFT) : points;
        next_state = ST_RESP;
        if (dec_op == cfcd_pkg::OP_NONE) begin
          next_resp_err = cfcd_pkg::ERR_UNKNOWN;
        end else if (dec_write && write_locked) begin
          next_resp_err = cfcd_pkg::ERR_RUN_PROTECT;
        end else if (dec_op == cfcd_pkg::OP_DEV_WATCH_RUN) begin
          next_resp_nak = 1'b0;
          next_count = dev_count;
          next_state = (dev_count == cfcd_pkg::RST_COUNT) ? ST_RESP : ST_ACCESS;
        end else if (dec_op == cfcd_pkg::OP_XFILE_WATCH_RUN) begin
          next_resp_nak = 1'b0;
          next_count = xf_count;
          next_state = (xf_count == cfcd_pkg::RST_COUNT) ? ST_RESP : ST_ACCESS;
        end else if ((points == cfcd_pkg::RST_COUNT) || (points > dec_limit) ||
                     (dec_group && ((points & cfcd_pkg::GROUP_MASK) != cfcd_pkg::RST_COUNT))) begin
          next_resp_err = cfcd_pkg::ERR_COUNT;
        end else begin
          next_resp_nak = 1'b0;
          next_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (ACC_READY) begin
          next_acc_index = ACC_INDEX + cfcd_pkg::PTS_W'(1);
          next_acc_addr = addr_step;
          if ((ACC_OP == cfcd_pkg::OP_XFILE_FLAT_READ) ||
              (ACC_OP == cfcd_pkg::OP_XFILE_FLAT_WRITE)) begin
            next_acc_block = addr_step[cfcd_pkg::ADDR_W-1:cfcd_pkg::XF_BLOCK_LSB];
          end
          if (next_acc_index == count) begin
            next_state = ST_RESP;
          end
        end
      end
      ST_RESP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State and output registers
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      code_hi <= 8'h00;
      code_lo <= 8'h00;
      points <= cfcd_pkg::RST_COUNT;
      start_addr <= cfcd_pkg::RST_ADDR;
      count <= cfcd_pkg::RST_COUNT;
      ACC_OP <= cfcd_pkg::OP_NONE;
      ACC_WRITE <= 1'b0;
      ACC_INDEX <= cfcd_pkg::RST_COUNT;
      ACC_ADDR <= cfcd_pkg::RST_ADDR;
      ACC_BLOCK <= cfcd_pkg::BLK_W'(0);
      RESP_NAK <= 1'b0;
      RESP_ERR <= cfcd_pkg::ERR_NONE;
    end else begin
      state <= next_state;
      code_hi <= next_code_hi;
      code_lo <= next_code_lo;
      points <= next_points;
      start_addr <= next_start_addr;
      count <= next_count;
      ACC_OP <= next_acc_op;
      ACC_WRITE <= next_acc_write;
      ACC_INDEX <= next_acc_index;
      ACC_ADDR <= next_acc_addr;
      ACC_BLOCK <= next_acc_block;
      RESP_NAK <= next_resp_nak;
      RESP_ERR <= next_resp_err;
    end
  end

endmodule

`default_nettype wire

/* common/cfcd_pkg.sv */
package cfcd_pkg;

  // Field widths
  localparam int PTS_W = 9;
  localparam int ADDR_W = 20;
  localparam int BLK_W = 5;
  localparam int ERR_W = 2;

  // ASCII characters that form the command code pairs
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_J = 8'h4A;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_Q = 8'h51;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_W = 8'h57;

  // Per-command limits, in points (bytes for the unit buffer)
  localparam logic [PTS_W-1:0] LIM_BIT16_WR = 9'h0A0;
  localparam logic [PTS_W-1:0] LIM_WORD_WR = 9'h040;
  localparam logic [PTS_W-1:0] LIM_BIT_TEST = 9'h014;
  localparam logic [PTS_W-1:0] LIM_BIT16_TEST = 9'h0A0;
  localparam logic [PTS_W-1:0] LIM_WORD_RAND = 9'h00A;
  localparam logic [PTS_W-1:0] LIM_BIT_WATCH = 9'h028;
  localparam logic [PTS_W-1:0] LIM_BIT16_WATCH = 9'h140;
  localparam logic [PTS_W-1:0] LIM_WORD_WATCH = 9'h014;
  localparam logic [PTS_W-1:0] LIM_UBUF_WR = 9'h080;
  localparam logic [PTS_W-1:0] LIM_UBUF_RD = 9'h080;
  localparam logic [PTS_W-1:0] LIM_XF_BATCH = 9'h040;
  localparam logic [PTS_W-1:0] LIM_XF_RAND = 9'h00A;
  localparam logic [PTS_W-1:0] LIM_XF_WATCH = 9'h014;
  localparam logic [PTS_W-1:0] LIM_XF_FLAT = 9'h040;

  // Sixteen-point groups: count shift and remainder mask
  localparam int GROUP_SHIFT = 4;
  localparam logic [PTS_W-1:0] GROUP_MASK = 9'h00F;

  // Flat serial number: block number starts at this bit
  localparam int XF_BLOCK_LSB = 15;

  // Reset values
  localparam logic [PTS_W-1:0] RST_COUNT = 9'h000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 20'h00000;

  // Answer codes
  localparam logic [ERR_W-1:0] ERR_NONE = 2'h0;
  localparam logic [ERR_W-1:0] ERR_UNKNOWN = 2'h1;
  localparam logic [ERR_W-1:0] ERR_COUNT = 2'h2;
  localparam logic [ERR_W-1:0] ERR_RUN_PROTECT = 2'h3;

  // Decoded operations
  typedef enum logic [4:0] {
    OP_NONE,
    OP_BIT16_BATCH_WRITE,
    OP_WORD_DEV_BATCH_WRITE,
    OP_SINGLE_BIT_TEST_SET,
    OP_BIT16_TEST_SET,
    OP_WORD_RANDOM_WRITE,
    OP_SINGLE_BIT_WATCH_REGISTER,
    OP_BIT16_WATCH_REGISTER,
    OP_WORD_WATCH_REGISTER,
    OP_DEV_WATCH_RUN,
    OP_UNIT_BUFFER_READ,
    OP_UNIT_BUFFER_WRITE,
    OP_XFILE_BATCH_READ,
    OP_XFILE_BATCH_WRITE,
    OP_XFILE_RANDOM_WRITE,
    OP_XFILE_WATCH_REGISTER,
    OP_XFILE_WATCH_RUN,
    OP_XFILE_FLAT_READ,
    OP_XFILE_FLAT_WRITE
  } cfcd_op_e;

endpackage

/* src/cfcd_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module cfcd_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  // Second flop is the only reader of the first
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // Two-flop synchroniser, cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

`default_nettype wire

/* src/cfcd_watch.sv */
`timescale 1ns/1ps
`default_nettype none

module cfcd_watch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Registration strobe from the decoder
  input wire logic reg_we,
  input wire logic reg_xfile,
  input wire logic [cfcd_pkg::PTS_W-1:0] reg_count,
  // Access counts of the last registered sets
  output logic [cfcd_pkg::PTS_W-1:0] dev_count,
  output logic [cfcd_pkg::PTS_W-1:0] xf_count
);

  logic [cfcd_pkg::PTS_W-1:0] next_dev_count;
  logic [cfcd_pkg::PTS_W-1:0] next_xf_count;

  // A new registration replaces the whole previous set
  always_comb begin
    next_dev_count = dev_count;
    next_xf_count = xf_count;
    if (reg_we && !reg_xfile) begin
      next_dev_count = reg_count;
    end
    if (reg_we && reg_xfile) begin
      next_xf_count = reg_count;
    end
  end

  // Empty tables after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dev_count <= cfcd_pkg::RST_COUNT;
      xf_count <= cfcd_pkg::RST_COUNT;
    end else begin
      dev_count <= next_dev_count;
      xf_count <= next_xf_count;
    end
  end

endmodule

`default_nettype wire

/* tb/cfcd_decoder_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module cfcd_decoder_asserts (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Command side
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire logic [7:0] CMD_CODE_HI,
  input wire logic [7:0] CMD_CODE_LO,
  input wire logic [cfcd_pkg::PTS_W-1:0] CMD_POINTS,
  input wire logic [cfcd_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic CPU_RUN,
  input wire logic RUN_WRITE_PERMIT,
  // Access and answer side
  input wire logic ACC_VALID,
  input wire logic ACC_READY,
  input wire cfcd_pkg::cfcd_op_e ACC_OP,
  input wire logic [cfcd_pkg::PTS_W-1:0] ACC_INDEX,
  input wire logic [cfcd_pkg::ADDR_W-1:0] ACC_ADDR,
  input wire logic [cfcd_pkg::BLK_W-1:0] ACC_BLOCK,
  input wire logic RESP_VALID,
  input wire logic RESP_NAK,
  input wire logic [cfcd_pkg::ERR_W-1:0] RESP_ERR
);
  logic take;
  logic [7:0] cap_hi, cap_lo, next_cap_hi, next_cap_lo;
  logic [cfcd_pkg::PTS_W-1:0] cap_pts, next_cap_pts, hs_cnt, next_hs_cnt;
  logic [cfcd_pkg::ADDR_W-1:0] cap_addr, next_cap_addr;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  // Capture each command and count its handshakes from zero
  assign take = CMD_VALID && CMD_READY;
  always_comb begin
    next_cap_hi = take ? CMD_CODE_HI : cap_hi;
    next_cap_lo = take ? CMD_CODE_LO : cap_lo;
    next_cap_pts = take ? CMD_POINTS : cap_pts;
    next_cap_addr = take ? CMD_ADDR : cap_addr;
    next_hs_cnt = take ? 9'h000 : hs_cnt + {8'h00, ACC_VALID && ACC_READY};
  end
  always_ff @(posedge REF_CLK) begin
    cap_hi <= next_cap_hi;
    cap_lo <= next_cap_lo;
    cap_pts <= next_cap_pts;
    cap_addr <= next_cap_addr;
    hs_cnt <= RSTN ? next_hs_cnt : 9'h000;
  end

  // Pins held steady long enough to pass the two-flop synchronisers
  sequence take_s; CMD_VALID && CMD_READY; endsequence
  sequence pins_idle_s; (!CPU_RUN) [*4]; endsequence
  sequence pins_locked_s; (CPU_RUN && !RUN_WRITE_PERMIT) [*4]; endsequence

  resp_one_cycle_a: assert property (RESP_VALID |=> !RESP_VALID)
    else $error("answer strobe too long");
  busy_after_take_a: assert property (take_s |=> !CMD_READY [*2])
    else $error("command accepted while busy");
  unknown_code_a: assert property (take_s ##0 !(CMD_CODE_HI inside
    {8'h42, 8'h45, 8'h4A, 8'h4D, 8'h4E, 8'h51, 8'h54, 8'h57}) |-> ##1 !ACC_VALID
    ##1 (!ACC_VALID && RESP_VALID && RESP_NAK && RESP_ERR == cfcd_pkg::ERR_UNKNOWN))
    else $error("unknown pair not refused");
  group_count_err_a: assert property (pins_idle_s ##0 take_s ##0
    (CMD_CODE_HI == 8'h57 && CMD_CODE_LO == 8'h57 && (CMD_POINTS > cfcd_pkg::LIM_BIT16_WR
    || CMD_POINTS[3:0] != 4'h0 || CMD_POINTS == 9'h000)) |-> ##2
    (RESP_VALID && RESP_NAK && RESP_ERR == cfcd_pkg::ERR_COUNT))
    else $error("bad group count not refused");
  run_protect_a: assert property (pins_locked_s ##0 take_s ##0
    (CMD_CODE_HI == 8'h51 && CMD_CODE_LO == 8'h57) |-> ##2
    (RESP_VALID && RESP_NAK && RESP_ERR == cfcd_pkg::ERR_RUN_PROTECT))
    else $error("protected write not refused");
  acc_hold_a: assert property (ACC_VALID && !ACC_READY |=> ACC_VALID
    && $stable(ACC_INDEX) && $stable(ACC_ADDR) && $stable(ACC_OP))
    else $error("access changed while waiting");
  index_step_a: assert property (ACC_VALID && ACC_READY ##1 ACC_VALID |->
    ACC_INDEX == $past(ACC_INDEX) + 9'h001)
    else $error("access index did not step by one");
  addr_sum_a: assert property (ACC_VALID |->
    ACC_ADDR == 20'(cap_addr + {11'h000, ACC_INDEX}))
    else $error("address not start plus index");
  flat_block_a: assert property (ACC_VALID |-> ACC_BLOCK ==
    ((ACC_OP inside {cfcd_pkg::OP_XFILE_FLAT_READ, cfcd_pkg::OP_XFILE_FLAT_WRITE}) ?
    ACC_ADDR[cfcd_pkg::ADDR_W-1:cfcd_pkg::XF_BLOCK_LSB] : 5'h00))
    else $error("wrong block number");
  word_count_a: assert property (RESP_VALID && !RESP_NAK && cap_hi == 8'h51
    && cap_lo == 8'h57 |-> hs_cnt == cap_pts)
    else $error("word write access count wrong");
  group_count_a: assert property (RESP_VALID && !RESP_NAK && cap_hi == 8'h57
    && cap_lo == 8'h57 |-> hs_cnt == (cap_pts >> 4))
    else $error("group write access count wrong");
endmodule

bind cfcd_decoder cfcd_decoder_asserts u_cfcd_decoder_asserts (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .CMD_CODE_HI(CMD_CODE_HI), .CMD_CODE_LO(CMD_CODE_LO), .CMD_POINTS(CMD_POINTS),
  .CMD_ADDR(CMD_ADDR), .CPU_RUN(CPU_RUN), .RUN_WRITE_PERMIT(RUN_WRITE_PERMIT),
  .ACC_VALID(ACC_VALID), .ACC_READY(ACC_READY), .ACC_OP(ACC_OP), .ACC_INDEX(ACC_INDEX),
  .ACC_ADDR(ACC_ADDR), .ACC_BLOCK(ACC_BLOCK), .RESP_VALID(RESP_VALID),
  .RESP_NAK(RESP_NAK), .RESP_ERR(RESP_ERR)
);

`default_nettype wire

/* tb/cfcd_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cfcd_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Access handshake
  input wire logic acc_valid,
  output logic acc_ready,
  // Pacing and tally
  input wire logic slow,
  output var int hits
);
  logic [1:0] phase;

  // Slow pacing answers one cycle in three, so requests must hold
  assign acc_ready = !slow || (phase == 2'h2);
  always_ff @(posedge clk) begin
    phase <= (!rst_n || phase == 2'h2) ? 2'h0 : phase + 2'h1;
    hits <= rst_n ? hits + int'(acc_valid && acc_ready) : 0;
  end
endmodule

`default_nettype wire

/* tb/cfcd_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("BAD %s expected %0h seen %0h", what, exp, got); \
  end \
end

module cfcd_decoder_test;
  logic ref_clk, rstn, cmd_valid, cmd_ready, cpu_run, run_write_permit, slow;
  logic acc_valid, acc_ready, acc_write, resp_valid, resp_nak;
  logic [7:0] code_hi, code_lo;
  logic [cfcd_pkg::PTS_W-1:0] points, acc_index;
  logic [cfcd_pkg::ADDR_W-1:0] addr, acc_addr;
  logic [cfcd_pkg::BLK_W-1:0] acc_block;
  logic [cfcd_pkg::ERR_W-1:0] resp_err;
  cfcd_pkg::cfcd_op_e acc_op;
  int hits, num_errors, total_checks, cycles;

  cfcd_decoder u_cfcd_decoder (.REF_CLK(ref_clk), .RSTN(rstn), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_CODE_HI(code_hi), .CMD_CODE_LO(code_lo),
    .CMD_POINTS(points), .CMD_ADDR(addr), .CPU_RUN(cpu_run),
    .RUN_WRITE_PERMIT(run_write_permit), .ACC_VALID(acc_valid), .ACC_READY(acc_ready),
    .ACC_OP(acc_op), .ACC_WRITE(acc_write), .ACC_INDEX(acc_index), .ACC_ADDR(acc_addr),
    .ACC_BLOCK(acc_block), .RESP_VALID(resp_valid), .RESP_NAK(resp_nak),
    .RESP_ERR(resp_err));
  cfcd_mem_model u_cfcd_mem_model (.clk(ref_clk), .rst_n(rstn), .acc_valid(acc_valid),
    .acc_ready(acc_ready), .slow(slow), .hits(hits));

  // Free-running 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("BAD timeout expected finish seen hang");
      tally_and_finish();
    end
  end

  // One command: offer when idle, wait for the answer, judge it
  task automatic run_cmd(input logic [7:0] hi, input logic [7:0] lo,
      input logic [cfcd_pkg::PTS_W-1:0] pts, input logic [cfcd_pkg::ERR_W-1:0] err,
      input int n);
    int base, w;
    do @(negedge ref_clk); while (cmd_ready !== 1'b1);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    code_hi <= hi;
    code_lo <= lo;
    points <= pts;
    addr <= addr + 20'h00101;
    base = hits;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    w = 0;
    do begin
      @(negedge ref_clk);
      w++;
    end while (resp_valid !== 1'b1 && w < 1000);
    `CHK("answer strobe", 1'b1, resp_valid)
    `CHK("negative flag", err != cfcd_pkg::ERR_NONE, resp_nak)
    `CHK("answer code", err, resp_err)
    `CHK("access count", n, hits - base)
    `CHK("write flag", lo == 8'h57 || lo == 8'h54, acc_write)
  endtask

  task automatic t_reset();
    @(negedge ref_clk);
    `CHK("idle ready", 1'b1, cmd_ready)
    `CHK("idle access", 1'b0, acc_valid)
    `CHK("idle answer", 1'b0, resp_valid)
    `CHK("idle op", cfcd_pkg::OP_NONE, acc_op)
    `CHK("idle write", 1'b0, acc_write)
    $display("t_reset done");
  endtask

  task automatic t_watch();
    logic [7:0] mon [4] = '{8'h42, 8'h4A, 8'h4E, 8'h51};
    run_cmd(8'h4D, 8'h45, 9'h001, cfcd_pkg::ERR_NONE, 0);
    run_cmd(8'h51, 8'h4D, 9'h005, cfcd_pkg::ERR_NONE, 5);
    foreach (mon[i]) begin
      run_cmd(8'h4D, mon[i], 9'h000, cfcd_pkg::ERR_NONE, 5);
    end
    run_cmd(8'h57, 8'h4D, 9'h030, cfcd_pkg::ERR_NONE, 3);
    run_cmd(8'h4D, 8'h51, 9'h000, cfcd_pkg::ERR_NONE, 3);
    run_cmd(8'h4A, 8'h4D, 9'h029, cfcd_pkg::ERR_COUNT, 0);
    run_cmd(8'h4D, 8'h42, 9'h000, cfcd_pkg::ERR_NONE, 3);
    run_cmd(8'h45, 8'h4D, 9'h007, cfcd_pkg::ERR_NONE, 7);
    run_cmd(8'h4D, 8'h45, 9'h000, cfcd_pkg::ERR_NONE, 7);
    $display("t_watch done");
  endtask

  task automatic t_limits();
    logic [31:0] tab [17] = '{32'h5757_00A0, 32'h5157_0040,
      32'h4254_0014, 32'h4A54_0014, 32'h5754_00A0, 32'h5154_000A,
      32'h4A4D_0028, 32'h574D_0140, 32'h514D_0014, 32'h5452_0080,
      32'h5457_0080, 32'h4552_0040, 32'h4557_0040, 32'h4554_000A,
      32'h454D_0014, 32'h4E52_0040, 32'h4E57_0040};
    logic grp;
    foreach (tab[i]) begin
      grp = tab[i][31:24] == cfcd_pkg::CH_W;
      run_cmd(tab[i][31:24], tab[i][23:16], tab[i][8:0], cfcd_pkg::ERR_NONE,
        grp ? int'(tab[i][8:4]) : int'(tab[i][8:0]));
      run_cmd(tab[i][31:24], tab[i][23:16], tab[i][8:0] + (grp ? 9'h010 : 9'h001),
        cfcd_pkg::ERR_COUNT, 0);
    end
    $display("t_limits done");
  endtask

  task automatic t_refuse();
    run_cmd(8'h41, 8'h41, 9'h001, cfcd_pkg::ERR_UNKNOWN, 0);
    run_cmd(8'h4D, 8'h4D, 9'h1FF, cfcd_pkg::ERR_UNKNOWN, 0);
    run_cmd(8'h57, 8'h57, 9'h011, cfcd_pkg::ERR_COUNT, 0);
    run_cmd(8'h51, 8'h57, 9'h000, cfcd_pkg::ERR_COUNT, 0);
    $display("t_refuse done");
  endtask

  task automatic t_protect();
    @(posedge ref_clk);
    cpu_run <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run_cmd(8'h51, 8'h57, 9'h002, cfcd_pkg::ERR_RUN_PROTECT, 0);
    run_cmd(8'h57, 8'h57, 9'h1FF, cfcd_pkg::ERR_RUN_PROTECT, 0);
    run_cmd(8'h41, 8'h41, 9'h001, cfcd_pkg::ERR_UNKNOWN, 0);
    run_cmd(8'h45, 8'h52, 9'h002, cfcd_pkg::ERR_NONE, 2);
    run_cmd(8'h4D, 8'h45, 9'h000, cfcd_pkg::ERR_NONE, 20);
    @(posedge ref_clk);
    run_write_permit <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run_cmd(8'h51, 8'h57, 9'h002, cfcd_pkg::ERR_NONE, 2);
    @(posedge ref_clk);
    cpu_run <= 1'b0;
    $display("t_protect done");
  endtask

  // Slow memory; flat write straddles a block boundary
  task automatic t_stall();
    @(posedge ref_clk);
    slow <= 1'b1;
    addr <= 20'h07EFD;
    run_cmd(8'h4E, 8'h57, 9'h004, cfcd_pkg::ERR_NONE, 4);
    run_cmd(8'h54, 8'h57, 9'h080, cfcd_pkg::ERR_NONE, 128);
    @(posedge ref_clk);
    slow <= 1'b0;
    $display("t_stall done");
  endtask

  // Reset, then the scenarios in an order that fixes the watch tables
  initial begin
    {rstn, cmd_valid, cpu_run, run_write_permit, slow} = 5'h00;
    {code_hi, code_lo, points, addr} = 45'h0;
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_watch();
    t_limits();
    t_refuse();
    t_protect();
    t_stall();
    tally_and_finish();
  end
endmodule

`default_nettype wire
